// ===== hw/mvr_pkg.sv
// Purpose: shared constants and types of the vendor management register bank
// Assumes: 16-bit management registers reached over a serial management frame
// Notes:   offsets, field positions, reset values and frame lengths live here

package mvr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] MVR_GCTL_ADDR = 16'h0000;
  localparam logic [15:0] MVR_STAT_ADDR = 16'h0010;
  localparam logic [15:0] MVR_CNT_ADDR = 16'h0011;
  localparam logic [15:0] MVR_GCTL_RST = 16'h0610;
  localparam logic [4:0] MVR_DEVAD = 5'h1e;

  // ----------------------------------------------------------------
  // global control fields
  // ----------------------------------------------------------------
  localparam int MVR_GRST_BIT = 15;
  localparam int MVR_SEL_HI = 14;
  localparam int MVR_SEL_LO = 12;
  localparam int MVR_RSV_HI = 10;
  localparam int MVR_RSV_LO = 7;
  localparam int MVR_PINDIS_BIT = 5;
  localparam int MVR_SRC_HI = 4;
  localparam logic [2:0] MVR_FN_STOPWATCH = 3'h0;
  localparam logic [2:0] MVR_FN_TXSW = 3'h2;
  localparam logic [2:0] MVR_FN_RXSW = 3'h3;
  localparam logic [4:0] MVR_SRC_HS = 5'h00;
  localparam logic [4:0] MVR_SRC_L0 = 5'h02;
  localparam logic [4:0] MVR_SRC_L1 = 5'h04;
  localparam logic [4:0] MVR_SRC_L2 = 5'h06;
  localparam logic [4:0] MVR_SRC_L3 = 5'h07;
  localparam logic [15:0] MVR_CNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // frame coding
  // ----------------------------------------------------------------
  localparam logic [1:0] MVR_ST_C45 = 2'b00;
  localparam logic [1:0] MVR_ST_C22 = 2'b01;
  localparam logic [1:0] MVR_OP45_ADDR = 2'b00;
  localparam logic [1:0] MVR_OP45_WR = 2'b01;
  localparam logic [1:0] MVR_OP45_RDINC = 2'b10;
  localparam logic [1:0] MVR_OP22_WR = 2'b01;
  localparam logic [1:0] MVR_OP22_RD = 2'b10;
  localparam logic [5:0] MVR_PRE_LEN = 6'd32;
  localparam logic [5:0] MVR_HDR_LAST = 6'd13;
  localparam logic [5:0] MVR_TAIL_LAST = 6'd17;

  typedef enum logic [1:0] {
    MVR_MODE_KR = 2'b00,
    MVR_MODE_KX = 2'b01,
    MVR_MODE_GP = 2'b10
  } mvr_mode_t;

  typedef enum logic [2:0] {
    MVR_FR_IDLE = 3'b001,
    MVR_FR_HDR = 3'b010,
    MVR_FR_TAIL = 3'b100
  } mvr_fr_state_t;
endpackage

// ===== hw/mvr_latch_cell.sv
// Purpose: one latched status bit, latching high or low
// Assumes: cond and clear strobes on clk
// Notes:   a condition present in the clearing cycle wins over the clear

`timescale 1ns/1ps
`default_nettype none

module mvr_latch_cell #(
  parameter logic LATCH_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_rst,
  input wire logic cond,
  input wire logic rd_clr,
  output logic q
);
  logic q_r;
  logic q_nxt;

  always_comb begin
    if (soft_rst) begin
      q_nxt = ~LATCH_VAL;
    end else if (cond) begin
      q_nxt = LATCH_VAL;
    end else if (rd_clr) begin
      q_nxt = ~LATCH_VAL;
    end else begin
      q_nxt = q_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= ~LATCH_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

`default_nettype wire

// ===== hw/mvr_mdio_frame.sv
// Purpose: serial management frame engine, both framing styles
// Assumes: mdc_rise and mdio_s already synchronised to clk
// Notes:   preamble of 32 ones required before every frame

`timescale 1ns/1ps
`default_nettype none

module mvr_mdio_frame (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc_rise,
  input wire logic mdio_s,
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] rd_data,
  output logic [15:0] acc_addr,
  output logic wr_stb,
  output logic [15:0] wr_data,
  output logic rd_stb,
  output logic mdio_out,
  output logic mdio_oe
);
  import mvr_pkg::*;

  mvr_fr_state_t st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt, tx_r, tx_nxt, addr_r, addr_nxt, wd_r, wd_nxt;
  logic c45_r, c45_nxt, hit_r, hit_nxt, rd_r, rd_nxt;
  logic [1:0] op_r, op_nxt;
  logic oe_r, oe_nxt, out_r, out_nxt, wstb_r, wstb_nxt, rstb_r, rstb_nxt;
  logic [13:0] hdr;
  logic [15:0] dat;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    c45_nxt = c45_r;
    hit_nxt = hit_r;
    rd_nxt = rd_r;
    op_nxt = op_r;
    oe_nxt = oe_r;
    out_nxt = out_r;
    wstb_nxt = 1'b0;
    rstb_nxt = 1'b0;
    hdr = {sh_r[12:0], mdio_s};
    dat = {sh_r[14:0], mdio_s};
    if (mdc_rise) begin
      case (st_r)
        MVR_FR_IDLE: begin
          if (mdio_s) begin
            cnt_nxt = (cnt_r == MVR_PRE_LEN) ? cnt_r : cnt_r + 6'd1;
          end else if (cnt_r == MVR_PRE_LEN) begin
            st_nxt = MVR_FR_HDR;
            cnt_nxt = 6'd1;
            sh_nxt = 16'h0000;
          end else begin
            cnt_nxt = 6'd0;
          end
        end
        MVR_FR_HDR: begin
          sh_nxt = dat;
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == MVR_HDR_LAST) begin
            c45_nxt = (hdr[13:12] == MVR_ST_C45);
            op_nxt = hdr[11:10];
            hit_nxt = (hdr[9:5] == phy_addr) &&
                      (c45_nxt ? (hdr[4:0] == MVR_DEVAD) : (hdr[13:12] == MVR_ST_C22));
            rd_nxt = hit_nxt && (c45_nxt ? hdr[11] : (hdr[11:10] == MVR_OP22_RD));
            if (hit_nxt && !c45_nxt) begin
              addr_nxt = {11'h000, hdr[4:0]};
            end
            st_nxt = MVR_FR_TAIL;
            cnt_nxt = 6'd0;
          end
        end
        MVR_FR_TAIL: begin
          sh_nxt = dat;
          cnt_nxt = cnt_r + 6'd1;
          if (rd_r && cnt_r == 6'd0) begin
            tx_nxt = rd_data;
            oe_nxt = 1'b1;
            out_nxt = 1'b0;
          end else if (rd_r && cnt_r < MVR_TAIL_LAST) begin
            out_nxt = tx_r[15];
            tx_nxt = {tx_r[14:0], 1'b0};
          end
          if (cnt_r == MVR_TAIL_LAST) begin
            st_nxt = MVR_FR_IDLE;
            cnt_nxt = 6'd0;
            oe_nxt = 1'b0;
            out_nxt = 1'b0;
            rstb_nxt = rd_r;
            if (hit_r && c45_r && op_r == MVR_OP45_ADDR) begin
              addr_nxt = dat;
            end else if (hit_r && c45_r && op_r == MVR_OP45_RDINC) begin
              addr_nxt = addr_r + 16'h0001;
            end else if (hit_r && (c45_r ? op_r == MVR_OP45_WR : op_r == MVR_OP22_WR)) begin
              wstb_nxt = 1'b1;
              wd_nxt = dat;
            end
          end
        end
        default: begin
          st_nxt = MVR_FR_IDLE;
          cnt_nxt = 6'd0;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= MVR_FR_IDLE;
      cnt_r <= 6'd0;
      sh_r <= 16'h0000;
      tx_r <= 16'h0000;
      addr_r <= 16'h0000;
      wd_r <= 16'h0000;
      c45_r <= 1'b0;
      hit_r <= 1'b0;
      rd_r <= 1'b0;
      op_r <= 2'b00;
      oe_r <= 1'b0;
      out_r <= 1'b0;
      wstb_r <= 1'b0;
      rstb_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      c45_r <= c45_nxt;
      hit_r <= hit_nxt;
      rd_r <= rd_nxt;
      op_r <= op_nxt;
      oe_r <= oe_nxt;
      out_r <= out_nxt;
      wstb_r <= wstb_nxt;
      rstb_r <= rstb_nxt;
    end
  end

  assign acc_addr = addr_r;
  assign wr_stb = wstb_r;
  assign wr_data = wd_r;
  assign rd_stb = rstb_r;
  assign mdio_out = out_r;
  assign mdio_oe = oe_r;
endmodule

`default_nettype wire

// ===== hw/mvr_vendor_regs.sv
// Purpose: vendor management register bank with global control register
// Assumes: mdc much slower than clk; host changes mdio away from mdc rise
// Notes:   pattern status and mode inputs come from logic on clk

`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - read-write bits store and return written value
// - self-clearing bit pulses, always reads zero
// - read-only bits ignore writes, show live
// - latched-high sets on condition, read clears
// - latched-low clears on condition, read sets
// - counter clears on read, saturates at max
// - tagged fields honoured in every mode; only lane sources mode-gated
// - long framing answers device address 0x1e
// - short framing register field selects low bits
// - soft reset resets datapath and registers
// - soft reset bit clears next management clock
// - bits 14:12 choose address pin function
// - bit 5 low lets pin serve function
// - bits 4:0 route pattern result to pin
// - pin source needs enabled checker; lanes 1 to 3 mode-gated
// - reserved bits 11 and 6 read zero
module mvr_vendor_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic port_addr_bit0_pin,
  input wire mvr_pkg::mvr_mode_t mode,
  input wire logic hs_verify_en,
  input wire logic ls_verify_en,
  input wire logic hs_pattern_ok,
  input wire logic [3:0] ls_pattern_ok,
  input wire logic hs_err_evt,
  output logic datapath_reset,
  output logic stopwatch_in,
  output logic tx_data_switch,
  output logic rx_data_switch,
  output logic pattern_check_ok_pin
);
  import mvr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sync1_r, sync2_r;
  logic mdc_d_r;
  logic mdc_rise, mdio_s, pin_s;
  logic [4:0] pa_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      mdc_d_r <= 1'b0;
    end else begin
      sync1_r <= {phy_addr, port_addr_bit0_pin, mdio_in, mdc};
      sync2_r <= sync1_r;
      mdc_d_r <= sync2_r[0];
    end
  end

  assign mdc_rise = sync2_r[0] & ~mdc_d_r;
  assign mdio_s = sync2_r[1];
  assign pin_s = sync2_r[2];
  assign pa_s = sync2_r[7:3];

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  logic [15:0] acc_addr, wr_data, rd_data;
  logic wr_stb, rd_stb;

  mvr_mdio_frame u_frame (
    .clk(clk),
    .reset(reset),
    .mdc_rise(mdc_rise),
    .mdio_s(mdio_s),
    .phy_addr(pa_s),
    .rd_data(rd_data),
    .acc_addr(acc_addr),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_stb(rd_stb),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe)
  );

  // ----------------------------------------------------------------
  // global control register
  // ----------------------------------------------------------------
  logic [2:0] sel_r, sel_nxt;
  logic [3:0] rsv_r, rsv_nxt;
  logic pindis_r, pindis_nxt;
  logic [4:0] src_r, src_nxt;
  logic srst_r, srst_nxt;
  logic gctl_wr;

  assign gctl_wr = wr_stb && acc_addr == MVR_GCTL_ADDR;

  always_comb begin
    sel_nxt = sel_r;
    rsv_nxt = rsv_r;
    pindis_nxt = pindis_r;
    src_nxt = src_r;
    srst_nxt = srst_r;
    if (srst_r) begin
      // held over to the next mdc rise, registers forced to defaults meanwhile
      sel_nxt = MVR_GCTL_RST[MVR_SEL_HI:MVR_SEL_LO];
      rsv_nxt = MVR_GCTL_RST[MVR_RSV_HI:MVR_RSV_LO];
      pindis_nxt = MVR_GCTL_RST[MVR_PINDIS_BIT];
      src_nxt = MVR_GCTL_RST[MVR_SRC_HI:0];
      srst_nxt = ~mdc_rise;
    end else if (gctl_wr) begin
      sel_nxt = wr_data[MVR_SEL_HI:MVR_SEL_LO];
      rsv_nxt = wr_data[MVR_RSV_HI:MVR_RSV_LO];
      pindis_nxt = wr_data[MVR_PINDIS_BIT];
      src_nxt = wr_data[MVR_SRC_HI:0];
      srst_nxt = wr_data[MVR_GRST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_r <= MVR_GCTL_RST[MVR_SEL_HI:MVR_SEL_LO];
      rsv_r <= MVR_GCTL_RST[MVR_RSV_HI:MVR_RSV_LO];
      pindis_r <= MVR_GCTL_RST[MVR_PINDIS_BIT];
      src_r <= MVR_GCTL_RST[MVR_SRC_HI:0];
      srst_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      rsv_r <= rsv_nxt;
      pindis_r <= pindis_nxt;
      src_r <= src_nxt;
      srst_r <= srst_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status bits and error counter
  // ----------------------------------------------------------------
  logic stat_rd, cnt_rd, lh_q, ll_q, cnt_evt;
  logic [15:0] cnt_r, cnt_nxt;

  assign stat_rd = rd_stb && acc_addr == MVR_STAT_ADDR;
  assign cnt_rd = rd_stb && acc_addr == MVR_CNT_ADDR;
  assign cnt_evt = hs_err_evt & hs_verify_en;

  mvr_latch_cell #(.LATCH_VAL(1'b1)) u_hs_fail_lh (
    .clk(clk),
    .reset(reset),
    .soft_rst(srst_r),
    .cond(hs_verify_en & ~hs_pattern_ok),
    .rd_clr(stat_rd),
    .q(lh_q)
  );

  mvr_latch_cell #(.LATCH_VAL(1'b0)) u_ls0_ok_ll (
    .clk(clk),
    .reset(reset),
    .soft_rst(srst_r),
    .cond(ls_verify_en & ~ls_pattern_ok[0]),
    .rd_clr(stat_rd),
    .q(ll_q)
  );

  always_comb begin
    cnt_nxt = cnt_r;
    if (srst_r) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_rd) begin
      cnt_nxt = cnt_evt ? 16'h0001 : 16'h0000;
    end else if (cnt_evt && cnt_r != MVR_CNT_MAX) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (acc_addr)
      MVR_GCTL_ADDR: rd_data = {1'b0, sel_r, 1'b0, rsv_r, 1'b0, pindis_r, src_r};
      MVR_STAT_ADDR: rd_data = {10'h000, mode, 1'b0, ll_q, lh_q, hs_pattern_ok};
      MVR_CNT_ADDR: rd_data = cnt_r;
      default: rd_data = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // pin functions and pass pin
  // ----------------------------------------------------------------
  logic sw_r, sw_nxt, txs_r, txs_nxt, rxs_r, rxs_nxt, pass_r, pass_nxt;
  logic pin_on, lane_ok;

  // the tagged fields here apply in every mode; only the lane gating differs
  assign lane_ok = (mode != MVR_MODE_KX);
  assign pin_on = ~pindis_r & pin_s;

  always_comb begin
    sw_nxt = pin_on && sel_r == MVR_FN_STOPWATCH;
    txs_nxt = pin_on && sel_r == MVR_FN_TXSW;
    rxs_nxt = pin_on && sel_r == MVR_FN_RXSW;
    // unselected or reserved source other than codes 1x00 leaves the pin high, meaning no failure; codes 1x00 follow the high-speed checker
    pass_nxt = 1'b1;
    if (src_r == MVR_SRC_HS || (src_r[4] && src_r[1:0] == 2'b00)) begin
      pass_nxt = hs_verify_en ? hs_pattern_ok : 1'b1;
    end else if (src_r == MVR_SRC_L0) begin
      pass_nxt = ls_verify_en ? ls_pattern_ok[0] : 1'b1;
    end else if (src_r == MVR_SRC_L1 && lane_ok) begin
      pass_nxt = ls_verify_en ? ls_pattern_ok[1] : 1'b1;
    end else if (src_r == MVR_SRC_L2 && lane_ok) begin
      pass_nxt = ls_verify_en ? ls_pattern_ok[2] : 1'b1;
    end else if (src_r == MVR_SRC_L3 && lane_ok) begin
      pass_nxt = ls_verify_en ? ls_pattern_ok[3] : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sw_r <= 1'b0;
      txs_r <= 1'b0;
      rxs_r <= 1'b0;
      pass_r <= 1'b1;
    end else begin
      sw_r <= sw_nxt;
      txs_r <= txs_nxt;
      rxs_r <= rxs_nxt;
      pass_r <= pass_nxt;
    end
  end

  assign datapath_reset = srst_r;
  assign stopwatch_in = sw_r;
  assign tx_data_switch = txs_r;
  assign rx_data_switch = rxs_r;
  assign pattern_check_ok_pin = pass_r;
endmodule

`default_nettype wire

// ===== testbench/mvr_vendor_regs_chk.sv
// Purpose: port checks of the vendor register bank
// Assumes: one clock, synchronous reset
// Notes:   link pins reach the bank a few clk late
`timescale 1ns/1ps
`default_nettype none
module mvr_vendor_regs_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic port_addr_bit0_pin,
  input wire logic hs_verify_en,
  input wire logic ls_verify_en,
  input wire logic hs_pattern_ok,
  input wire logic [3:0] ls_pattern_ok,
  input wire logic datapath_reset,
  input wire logic stopwatch_in,
  input wire logic tx_data_switch,
  input wire logic rx_data_switch,
  input wire logic pattern_check_ok_pin
);
  logic [5:0] mdc_h_r;
  logic [5:0] pin_h_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic oe_r;
  logic fail_any;
  assign fail_any = (hs_verify_en && !hs_pattern_ok) || (ls_verify_en && ls_pattern_ok != 4'hf);
  // histories span the synchroniser delay of the bank
  always_comb begin
    cnt_nxt = cnt_r;
    if (mdio_oe && !oe_r) begin
      cnt_nxt = 5'h00;
    end else if (mdio_oe && mdc_h_r[0] && !mdc_h_r[1]) begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    mdc_h_r <= {mdc_h_r[4:0], mdc};
    pin_h_r <= {pin_h_r[4:0], port_addr_bit0_pin};
    oe_r <= mdio_oe;
    cnt_r <= cnt_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst;
    $fell(reset) |-> !mdio_oe && !datapath_reset && pattern_check_ok_pin && !stopwatch_in;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_ta;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  a_ta: assert property (p_ta) else $error("turnaround bit not zero");
  property p_len;
    $fell(mdio_oe) |-> cnt_r == 5'h11;
  endproperty
  a_len: assert property (p_len) else $error("read answer length wrong");
  property p_dp_hold;
    datapath_reset && mdc_h_r == 6'h00 && !mdc |=> datapath_reset;
  endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("soft reset ended early");
  property p_dp_end;
    $fell(datapath_reset) |-> |mdc_h_r;
  endproperty
  a_dp_end: assert property (p_dp_end) else $error("soft reset ended without mdc");
  property p_fn_one;
    $onehot0({stopwatch_in, tx_data_switch, rx_data_switch});
  endproperty
  a_fn_one: assert property (p_fn_one) else $error("two pin functions at once");
  property p_fn_pin;
    (stopwatch_in || tx_data_switch || rx_data_switch) |-> |pin_h_r;
  endproperty
  a_fn_pin: assert property (p_fn_pin) else $error("function high without pin");
  property p_off;
    (!hs_verify_en && !ls_verify_en) [*2] |-> pattern_check_ok_pin;
  endproperty
  a_off: assert property (p_off) else $error("pass pin low while unverified");
  property p_low;
    !pattern_check_ok_pin |-> $past(fail_any);
  endproperty
  a_low: assert property (p_low) else $error("pass pin low without failure");
endmodule
bind mvr_vendor_regs mvr_vendor_regs_chk u_chk (.clk, .reset, .mdc, .mdio_out, .mdio_oe, .port_addr_bit0_pin,
  .hs_verify_en, .ls_verify_en, .hs_pattern_ok, .ls_pattern_ok, .datapath_reset, .stopwatch_in,
  .tx_data_switch, .rx_data_switch, .pattern_check_ok_pin);
`default_nettype wire

// ===== testbench/mvr_sta_model.sv
// Purpose: station manager model on the management link
// Assumes: line pulled up while nobody drives it
// Notes:   mdc stands low between frames
`timescale 1ns/1ps
`default_nettype none
module mvr_sta_model (
  output var logic mdc,
  output logic mdio_w,
  input wire logic dev_out,
  input wire logic dev_oe
);
  logic host_en = 1'b0;
  logic host_v = 1'b0;
  assign mdio_w = dev_oe ? dev_out : (host_en ? host_v : 1'b1);
  initial mdc = 1'b0;
  // returns turnaround bit two and sixteen data bits
  task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [16:0] rd);
    logic [63:0] bits;
    logic is_rd;
    is_rd = (st == 2'b00) ? op[1] : (op == 2'b10);
    bits = {32'hffffffff, st, op, pa, ra, 2'b10, wd};
    for (int k = 63; k >= 0; k--) begin
      host_en = !(is_rd && k < 18);
      host_v = bits[k];
      #80;
      mdc = 1'b1;
      if (k < 17) begin
        rd[k] = mdio_w;
      end
      #80;
      mdc = 1'b0;
    end
    host_en = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/mvr_vendor_regs_tb.sv
// Purpose: self-checking bench of the vendor register bank
// Assumes: station model owns the link clock
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h seen %h", n, e, a); end end
module mvr_vendor_regs_tb;
  import mvr_pkg::*;
  localparam logic [4:0] PA = 5'h05;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pin = 1'b0;
  logic hs_en = 1'b0;
  logic ls_en = 1'b0;
  logic hs_ok = 1'b1;
  logic evt = 1'b0;
  logic [3:0] ls_ok = 4'hf;
  mvr_mode_t mode = MVR_MODE_KR;
  logic mdc, mdio_w, mdio_out, mdio_oe, dpr, sw, txs, rxs, okp;
  logic [16:0] rv;
  int bad_count = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  mvr_sta_model u_sta (.mdc(mdc), .mdio_w(mdio_w), .dev_out(mdio_out), .dev_oe(mdio_oe));
  mvr_vendor_regs u_dut (.clk, .reset, .mdc, .mdio_in(mdio_w), .mdio_out, .mdio_oe, .phy_addr(PA),
    .port_addr_bit0_pin(pin), .mode, .hs_verify_en(hs_en), .ls_verify_en(ls_en), .hs_pattern_ok(hs_ok),
    .ls_pattern_ok(ls_ok), .hs_err_evt(evt), .datapath_reset(dpr), .stopwatch_in(sw),
    .tx_data_switch(txs), .rx_data_switch(rxs), .pattern_check_ok_pin(okp));
  // ----------------------------------------
  // link access
  // ----------------------------------------
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic [1:0] st, input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    u_sta.frame(st, op, PA, ra, wd, rv);
  endtask
  task automatic rd45(input logic [15:0] a, input logic [15:0] e, input string n);
    acc(MVR_ST_C45, MVR_OP45_ADDR, MVR_DEVAD, a);
    acc(MVR_ST_C45, 2'b11, MVR_DEVAD, 16'h0000);
    `CK(n, {1'b0, e}, rv)
  endtask
  task automatic rd22(input logic [4:0] r, input logic [15:0] e, input string n);
    acc(MVR_ST_C22, MVR_OP22_RD, r, 16'h0000);
    `CK(n, {1'b0, e}, rv)
  endtask
  task automatic wr22(input logic [4:0] r, input logic [15:0] v);
    acc(MVR_ST_C22, MVR_OP22_WR, r, v);
  endtask
  task automatic t_rw();
    rd45(MVR_GCTL_ADDR, MVR_GCTL_RST, "gctl reset");
    acc(MVR_ST_C45, MVR_OP45_WR, MVR_DEVAD, 16'h7fff);
    rd45(MVR_GCTL_ADDR, 16'h77bf, "gctl ones");
    wr22(5'h00, 16'h0000);
    rd22(5'h00, 16'h0000, "gctl zeros");
    $display("end of rw");
  endtask
  task automatic t_fn();
    logic [2:0] fns [3];
    fns = '{MVR_FN_STOPWATCH, MVR_FN_TXSW, MVR_FN_RXSW};
    @(posedge clk) pin <= 1'b1;
    foreach (fns[i]) begin
      wr22(5'h00, {1'b0, fns[i], 12'h610});
      wclk(8);
      `CK("fn", {fns[i] == MVR_FN_STOPWATCH, fns[i] == MVR_FN_TXSW, fns[i] == MVR_FN_RXSW}, {sw, txs, rxs})
      @(posedge clk) pin <= 1'b0;
      wclk(8);
      `CK("fn low", 3'b000, {sw, txs, rxs})
      @(posedge clk) pin <= 1'b1;
    end
    wr22(5'h00, 16'h3630);
    wclk(8);
    `CK("fn off", 3'b000, {sw, txs, rxs})
    $display("end of pin function");
  endtask
  task automatic t_src();
    logic [4:0] codes [8];
    logic expv [8];
    codes = '{MVR_SRC_HS, 5'h10, 5'h1c, MVR_SRC_L0, MVR_SRC_L1, MVR_SRC_L2, MVR_SRC_L3, 5'h01};
    expv = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    @(posedge clk);
    hs_en <= 1'b1;
    ls_en <= 1'b1;
    hs_ok <= 1'b0;
    ls_ok <= 4'b0101;
    foreach (codes[i]) begin
      wr22(5'h00, 16'h0600 | codes[i]);
      wclk(4);
      `CK("pass src", expv[i], okp)
    end
    @(posedge clk) mode <= MVR_MODE_KX;
    wr22(5'h00, 16'h0600 | MVR_SRC_L1);
    wclk(4);
    `CK("pass kx", 1'b1, okp)
    @(posedge clk) ls_en <= 1'b0;
    wclk(4);
    `CK("pass off", 1'b1, okp)
    $display("end of pass source");
  endtask
  task automatic t_latch();
    @(posedge clk);
    mode <= MVR_MODE_GP;
    ls_en <= 1'b1;
    hs_ok <= 1'b1;
    ls_ok <= 4'hf;
    wclk(4);
    wr22(5'h10, 16'h0002);
    rd22(5'h10, 16'h0027, "status idle");
    @(posedge clk);
    hs_ok <= 1'b0;
    ls_ok <= 4'he;
    repeat (5) @(posedge clk);
    hs_ok <= 1'b1;
    ls_ok <= 4'hf;
    rd45(MVR_GCTL_ADDR, 16'h0604, "gctl");
    rd22(5'h10, 16'h0023, "status event");
    rd22(5'h10, 16'h0025, "status again");
    $display("end of latched status");
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) evt <= 1'b1;
      @(posedge clk) evt <= 1'b0;
    end
  endtask
  task automatic t_cnt();
    @(posedge clk) hs_en <= 1'b0;
    pulse(3);
    @(posedge clk) hs_en <= 1'b1;
    wr22(5'h11, 16'h1234);
    pulse(5);
    wclk(2);
    rd22(5'h11, 16'h0005, "count");
    rd22(5'h11, 16'h0000, "count cleared");
    $display("end of counter");
  endtask
  task automatic t_refuse();
    acc(MVR_ST_C45, MVR_OP45_ADDR, 5'h1d, MVR_GCTL_ADDR);
    acc(MVR_ST_C45, MVR_OP45_WR, 5'h1d, 16'h0000);
    u_sta.frame(MVR_ST_C22, MVR_OP22_WR, PA ^ 5'h01, 5'h00, 16'h0000, rv);
    rd22(5'h00, 16'h0604, "gctl kept");
    acc(MVR_ST_C45, 2'b11, 5'h1d, 16'h0000);
    `CK("foreign read", 17'h1ffff, rv)
    $display("end of refusal");
  endtask
  task automatic t_srst();
    wr22(5'h00, 16'h8000);
    wclk(1);
    `CK("dp reset on", 1'b1, dpr)
    rd22(5'h00, MVR_GCTL_RST, "gctl after reset");
    `CK("dp reset off", 1'b0, dpr)
    $display("end of soft reset");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wclk(2);
    t_rw();
    t_fn();
    t_src();
    t_latch();
    t_cnt();
    t_refuse();
    t_srst();
    summarize();
  end
  // nearly three times the expected run
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
